// ===== inc/srig_pkg.sv
// Function
// - polarity low passes input, high inverts it
// - slope selector gives signal and its complement
// - selected signal buffered onto conditioned jack
// - interval functions: direct gates off, generator fed
// - manual timing: both direct gates held off
// - channel-one sum/frequency: only channel-two gate off
// - clear forces interval low, complement high
// - while low, channel-one path on, two off
// - channel-one edge sets high, swaps paths, data low
// - stays high until channel-two edge returns low
// - re-arms for channel one without further clear
// - interval pulse from channel-one to channel-two edge
// - interval pulse is measurement gate source
// - slope polarities choose rising or falling edges
//
// Purpose: shared constants and types for the slope, route and interval gate
// Assumes: AXI4-Lite register access with 32-bit data
// Notes:   register offsets are byte addresses, one aligned word each
package srig_pkg;

  // bus widths and answers
  localparam int unsigned   DATA_W      = 32;
  localparam int unsigned   ADDR_W      = 32;
  localparam int unsigned   STRB_W      = 4;
  localparam logic [1:0]    RESP_OKAY   = 2'h0;
  localparam logic [1:0]    RESP_SLVERR = 2'h2;

  // register byte offsets
  localparam logic [31:0]   OFF_CTRL    = 32'h0000_0000;
  localparam logic [31:0]   OFF_STATUS  = 32'h0000_0004;
  localparam logic [31:0]   OFF_CLEAR   = 32'h0000_0008;
  localparam logic [31:0]   OFF_COUNT   = 32'h0000_000C;

  // control field positions
  localparam int unsigned   CTRL_POL_ONE  = 0;
  localparam int unsigned   CTRL_POL_TWO  = 1;
  localparam int unsigned   CTRL_FUNC_LSB = 4;
  localparam int unsigned   FUNC_W        = 4;
  localparam int unsigned   CLEAR_BIT     = 0;

  // status field positions
  localparam int unsigned   ST_INTERVAL   = 0;
  localparam int unsigned   ST_SEL_ONE    = 1;
  localparam int unsigned   ST_SEL_TWO    = 2;
  localparam int unsigned   ST_PATH_ONE   = 3;
  localparam int unsigned   ST_PATH_TWO   = 4;
  localparam int unsigned   ST_DIRECT_ONE = 5;
  localparam int unsigned   ST_DIRECT_TWO = 6;
  localparam int unsigned   ST_GATE_SRC   = 7;

  // completed interval counter width and reset
  localparam int unsigned   COUNT_W       = 16;
  localparam logic [15:0]   COUNT_RESET   = 16'h0000;

  // measurement functions
  typedef enum logic [3:0] {
    FN_FREQ_ONE,
    FN_PERIOD_TWO,
    FN_WIDTH_TWO,
    FN_INTERVAL_VAR,
    FN_PERIOD_TWO_AVG,
    FN_WIDTH_TWO_AVG,
    FN_INTERVAL_AVG,
    FN_EVENTS_DURING,
    FN_RATIO,
    FN_CHANNEL_ONE_EVENT_SUM,
    FN_MANUAL
  } srig_func_t;

  // software control word
  typedef struct packed {
    logic [3:0] func;
    logic       pol_two;
    logic       pol_one;
  } srig_ctrl_t;

  localparam srig_ctrl_t CTRL_RESET = '{func: 4'h0, pol_two: 1'b0, pol_one: 1'b0};

  // routing gate enables for one function
  typedef struct packed {
    logic direct_one;
    logic direct_two;
    logic interval;
  } srig_route_t;

  // interval generator states
  typedef enum logic {IV_LOW, IV_HIGH} srig_iv_t;

endpackage

// ===== rtl/srig_sync_edge.sv
// Purpose: two-flop synchroniser with rising and falling edge detect
// Assumes: din is asynchronous to clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
module srig_sync_edge (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta;       // first stage, read only by stage two
  logic stable;     // second stage
  logic last;       // previous stable value for edges
  logic next_meta;
  logic next_stable;
  logic next_last;

  // shift chain next values
  always_comb begin
    next_meta   = din;
    next_stable = meta;
    next_last   = stable;
  end

  // chain registers, frozen while ce is low
  always_ff @(posedge clk) begin
    if (rst) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
    end else if (ce) begin
      meta   <= next_meta;
      stable <= next_stable;
      last   <= next_last;
    end
  end

  // edge strobes last one enabled cycle
  assign level = stable;
  assign rise  = stable & ~last;
  assign fall  = ~stable & last;

endmodule

// ===== rtl/srig_top.sv
// Purpose: slope select, routing gates and interval generator of a counter
// Assumes: clk 125 MHz, shaped channel inputs asynchronous, AXI4-Lite access
// Notes:   all outputs registered, so they trail the inputs by sync delay
`timescale 1ns/1ns
module srig_top
  import srig_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               first_input_channel,
  input  wire logic               second_input_channel,
  input  wire logic               interval_clear,
  output logic                    conditioned_signal_jack_one,
  output logic                    conditioned_signal_jack_two,
  output logic                    slope_one,
  output logic                    slope_one_n,
  output logic                    slope_two,
  output logic                    slope_two_n,
  output logic                    direct_route_one,
  output logic                    direct_route_two,
  output logic                    interval_out,
  output logic                    interval_out_n,
  output logic                    gate_source,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [DATA_W-1:0]  s_axi_wdata,
  input  wire logic [STRB_W-1:0]  s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  // true when an address hits a register word exactly
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [31:0] off);
    addr_is = (a == off);
  endfunction

  // routing gate pattern for a function code
  function automatic srig_route_t route_of(input logic [3:0] code);
    srig_route_t r;
    r = '{direct_one: 1'b1, direct_two: 1'b1, interval: 1'b0};
    case (srig_func_t'(code))
      FN_INTERVAL_VAR, FN_INTERVAL_AVG: begin
        r = '{direct_one: 1'b0, direct_two: 1'b0, interval: 1'b1};
      end
      FN_MANUAL: begin
        r = '{direct_one: 1'b0, direct_two: 1'b0, interval: 1'b0};
      end
      FN_FREQ_ONE, FN_CHANNEL_ONE_EVENT_SUM: begin
        r = '{direct_one: 1'b1, direct_two: 1'b0, interval: 1'b0};
      end
      default: begin
        r = '{direct_one: 1'b1, direct_two: 1'b1, interval: 1'b0};
      end
    endcase
    return r;
  endfunction

  // synchronised channel levels and edges
  logic        lvl_one;      // channel one level
  logic        rise_one;     // channel one rising edge
  logic        fall_one;     // channel one falling edge
  logic        lvl_two;      // channel two level
  logic        rise_two;     // channel two rising edge
  logic        fall_two;     // channel two falling edge

  srig_sync_edge u_sync_one (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .din   (first_input_channel),
    .level (lvl_one),
    .rise  (rise_one),
    .fall  (fall_one)
  );

  srig_sync_edge u_sync_two (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .din   (second_input_channel),
    .level (lvl_two),
    .rise  (rise_two),
    .fall  (fall_two)
  );

  // register state
  srig_ctrl_t              ctrl;          // polarities and function
  logic                    sw_clear;      // one-cycle clear from software
  logic [COUNT_W-1:0]      done_count;    // completed intervals, wraps
  srig_iv_t                iv_state;      // interval generator state

  // slope and routing view of this cycle
  logic                    sel_one;       // slope-selected channel one
  logic                    sel_two;       // slope-selected channel two
  logic                    edge_one;      // qualifying channel one edge
  logic                    edge_two;      // qualifying channel two edge
  logic                    path_one;      // channel one path into generator
  logic                    path_two;      // channel two path into generator
  logic                    iv_data;       // next-state data presented
  logic                    gen_clear;     // clear pulse into generator
  srig_route_t             route;         // gate enables

  // slope selection and edge qualification
  always_comb begin
    sel_one  = lvl_one ^ ctrl.pol_one;
    sel_two  = lvl_two ^ ctrl.pol_two;
    // edge of the selected signal; no glitch edge when polarity flips
    edge_one = ctrl.pol_one ? fall_one : rise_one;
    edge_two = ctrl.pol_two ? fall_two : rise_two;
    route    = route_of(ctrl.func);
    path_one = route.interval & (iv_state == IV_LOW);
    path_two = route.interval & (iv_state == IV_HIGH);
    iv_data  = (iv_state == IV_LOW);
    gen_clear = interval_clear | sw_clear;
  end

  // interval generator next state
  srig_iv_t           next_iv_state;
  logic [COUNT_W-1:0] next_done_count;

  always_comb begin
    next_iv_state   = iv_state;
    next_done_count = done_count;
    if (gen_clear) begin
      next_iv_state = IV_LOW;
    end else if (path_one && edge_one) begin
      next_iv_state = iv_data ? IV_HIGH : IV_LOW;
    end else if (path_two && edge_two) begin
      next_iv_state   = IV_LOW;
      next_done_count = done_count + 1'b1;
    end
    // leaving interval functions drops a running interval
    if (!route.interval) begin
      next_iv_state = IV_LOW;
    end
  end

  // interval generator registers
  always_ff @(posedge clk) begin
    if (rst) begin
      iv_state   <= IV_LOW;
      done_count <= COUNT_RESET;
    end else if (ce) begin
      iv_state   <= next_iv_state;
      done_count <= next_done_count;
    end
  end

  // pin outputs next values
  logic next_jack_one;
  logic next_jack_two;
  logic next_slope_one;
  logic next_slope_one_n;
  logic next_slope_two;
  logic next_slope_two_n;
  logic next_direct_one;
  logic next_direct_two;
  logic next_interval;
  logic next_interval_n;
  logic next_gate_source;

  always_comb begin
    next_jack_one    = sel_one;
    next_jack_two    = sel_two;
    next_slope_one   = sel_one;
    next_slope_one_n = ~sel_one;
    next_slope_two   = sel_two;
    next_slope_two_n = ~sel_two;
    next_direct_one  = sel_one & route.direct_one;
    next_direct_two  = sel_two & route.direct_two;
    next_interval    = (next_iv_state == IV_HIGH);
    next_interval_n  = (next_iv_state != IV_HIGH);
    // gate source only carries the interval in the interval functions
    next_gate_source = route.interval & (next_iv_state == IV_HIGH);
  end

  // pin output registers; interval pins track the state flop exactly
  always_ff @(posedge clk) begin
    if (rst) begin
      conditioned_signal_jack_one <= 1'b0;
      conditioned_signal_jack_two <= 1'b0;
      slope_one                   <= 1'b0;
      slope_one_n                 <= 1'b1;
      slope_two                   <= 1'b0;
      slope_two_n                 <= 1'b1;
      direct_route_one            <= 1'b0;
      direct_route_two            <= 1'b0;
      interval_out                <= 1'b0;
      interval_out_n              <= 1'b1;
      gate_source                 <= 1'b0;
    end else if (ce) begin
      conditioned_signal_jack_one <= next_jack_one;
      conditioned_signal_jack_two <= next_jack_two;
      slope_one                   <= next_slope_one;
      slope_one_n                 <= next_slope_one_n;
      slope_two                   <= next_slope_two;
      slope_two_n                 <= next_slope_two_n;
      direct_route_one            <= next_direct_one;
      direct_route_two            <= next_direct_two;
      interval_out                <= next_interval;
      interval_out_n              <= next_interval_n;
      gate_source                 <= next_gate_source;
    end
  end

  // status word seen by software
  logic [DATA_W-1:0] status_word;

  always_comb begin
    status_word                = '0;
    status_word[ST_INTERVAL]   = (iv_state == IV_HIGH);
    status_word[ST_SEL_ONE]    = sel_one;
    status_word[ST_SEL_TWO]    = sel_two;
    status_word[ST_PATH_ONE]   = path_one;
    status_word[ST_PATH_TWO]   = path_two;
    status_word[ST_DIRECT_ONE] = route.direct_one;
    status_word[ST_DIRECT_TWO] = route.direct_two;
    status_word[ST_GATE_SRC]   = route.interval;
  end

  // bus write side: address and data held until the response is taken
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [STRB_W-1:0] w_strb;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [DATA_W-1:0] next_w_data;
  logic [STRB_W-1:0] next_w_strb;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  srig_ctrl_t        next_ctrl;
  logic              next_sw_clear;
  logic              do_write;

  always_comb begin
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_awready  = s_axi_awready;
    next_wready   = s_axi_wready;
    next_bvalid   = s_axi_bvalid;
    next_bresp    = s_axi_bresp;
    next_ctrl     = ctrl;
    next_sw_clear = 1'b0;
    // both halves held and no response pending
    do_write      = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_addr = s_axi_awaddr;
      next_awready = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_wready = 1'b0;
    end
    if (do_write) begin
      next_bvalid = 1'b1;
      next_bresp  = RESP_OKAY;
      // all control fields sit in byte lane 0
      if (addr_is(aw_addr, OFF_CTRL)) begin
        if (w_strb[0]) begin
          next_ctrl.pol_one = w_data[CTRL_POL_ONE];
          next_ctrl.pol_two = w_data[CTRL_POL_TWO];
          next_ctrl.func    = w_data[CTRL_FUNC_LSB +: FUNC_W];
        end
      end else if (addr_is(aw_addr, OFF_CLEAR)) begin
        next_sw_clear = w_strb[0] & w_data[CLEAR_BIT];
      end else if (addr_is(aw_addr, OFF_STATUS) || addr_is(aw_addr, OFF_COUNT)) begin
        next_bresp = RESP_OKAY;  // read-only words ignore writes
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
  end

  // write side registers
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      ctrl          <= CTRL_RESET;
      sw_clear      <= 1'b0;
    end else if (ce) begin
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      ctrl          <= next_ctrl;
      sw_clear      <= next_sw_clear;
    end
  end

  // bus read side: data sampled at the address edge
  logic              next_arready;
  logic              next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]        next_rresp;

  always_comb begin
    next_arready = s_axi_arready;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = RESP_OKAY;
      next_rdata   = '0;
      if (addr_is(s_axi_araddr, OFF_CTRL)) begin
        next_rdata[CTRL_POL_ONE]             = ctrl.pol_one;
        next_rdata[CTRL_POL_TWO]             = ctrl.pol_two;
        next_rdata[CTRL_FUNC_LSB +: FUNC_W]  = ctrl.func;
      end else if (addr_is(s_axi_araddr, OFF_STATUS)) begin
        next_rdata = status_word;
      end else if (addr_is(s_axi_araddr, OFF_CLEAR)) begin
        next_rdata = '0;
      end else if (addr_is(s_axi_araddr, OFF_COUNT)) begin
        next_rdata[COUNT_W-1:0] = done_count;
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  // read side registers
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

endmodule

// ===== tb/srig_properties.sv
// Purpose: port checker for srig_top
// Assumes: one clock, all watched outputs registered
// Notes:   bound into every srig_top instance
`timescale 1ns/1ns
module srig_properties
  import srig_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        interval_clear,
  input wire logic        conditioned_signal_jack_one,
  input wire logic        conditioned_signal_jack_two,
  input wire logic        slope_one,
  input wire logic        slope_one_n,
  input wire logic        slope_two,
  input wire logic        slope_two_n,
  input wire logic        direct_route_one,
  input wire logic        direct_route_two,
  input wire logic        interval_out,
  input wire logic        interval_out_n,
  input wire logic        gate_source,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  logic [3:0] quiet; // cycles since a clear or write answer

  // a clear or a write may end an interval, so stop checks wait for quiet
  always_ff @(posedge clk) begin
    if (rst || s_axi_bvalid || interval_clear) quiet <= 4'h0;
    else if (quiet != 4'hF) quiet <= quiet + 4'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // qualifying edge is always a rise of the selected level
  sequence one_rose; slope_one && !$past(slope_one); endsequence
  sequence two_rose; slope_two && !$past(slope_two); endsequence

  AST_SLOPE_CMP: assert property (slope_one_n == !slope_one && slope_two_n == !slope_two)
    else $error("slope complement wrong");
  AST_JACK: assert property (conditioned_signal_jack_one == slope_one
    && conditioned_signal_jack_two == slope_two) else $error("jack differs from slope");
  AST_DIRECT_GATED: assert property (!(direct_route_one && !slope_one)
    && !(direct_route_two && !slope_two)) else $error("direct route not gated level");
  AST_IV_CMP: assert property (interval_out_n == !interval_out)
    else $error("interval complement wrong");
  AST_CLEAR: assert property (interval_clear |=> !interval_out)
    else $error("clear did not drop interval");
  AST_START: assert property ($rose(interval_out) |-> one_rose)
    else $error("start without channel one edge");
  AST_STOP: assert property ($fell(interval_out) && quiet > 4'h4 |-> two_rose)
    else $error("stop without channel two edge");
  AST_GATE_SRC: assert property (gate_source |-> interval_out)
    else $error("gate source without interval");
  AST_ROUTE_OFF: assert property (gate_source |-> !direct_route_one && !direct_route_two)
    else $error("direct gates open in interval function");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
endmodule

bind srig_top srig_properties u_props (.clk, .rst, .interval_clear, .conditioned_signal_jack_one,
  .conditioned_signal_jack_two, .slope_one, .slope_one_n, .slope_two, .slope_two_n,
  .direct_route_one, .direct_route_two, .interval_out, .interval_out_n, .gate_source,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// ===== tb/srig_partner.sv
// Purpose: shaped input front end, toggles each channel on request
// Assumes: lat changed only while no toggle is in flight
// Notes:   toggling alternates rising and falling edges
`timescale 1ns/1ns
module srig_partner (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       fire_one,
  input  wire logic       fire_two,
  input  wire logic [3:0] lat,
  output logic            ch_one,
  output logic            ch_two
);
  logic [15:0] d_one; // request delay line, channel one
  logic [15:0] d_two; // request delay line, channel two

  // amplifier delay: prompt at lat 0, slow up to 15 cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      {d_one, d_two, ch_one, ch_two} <= '0;
    end else begin
      d_one <= {d_one[14:0], fire_one};
      d_two <= {d_two[14:0], fire_two};
      ch_one <= ch_one ^ d_one[lat];
      ch_two <= ch_two ^ d_two[lat];
    end
  end
endmodule

// ===== tb/slope_route_interval_gate_bench.sv
// Purpose: self-checking bench for srig_top
// Assumes: AXI4-Lite master here, partner drives the shaped inputs
// Notes:   both channels share one delay, so pulse width equals gap
`timescale 1ns/1ns
module slope_route_interval_gate_bench
  import srig_pkg::*;
;
  logic clk, rst, ce, first_input_channel, second_input_channel, interval_clear;
  logic conditioned_signal_jack_one, conditioned_signal_jack_two, slope_one, slope_one_n;
  logic slope_two, slope_two_n, direct_route_one, direct_route_two;
  logic interval_out, interval_out_n, gate_source, fire_one, fire_two;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [STRB_W-1:0] s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]  lat;          // partner delay
  logic [33:0] rq[$];        // expected read answers
  logic [1:0]  wq[$];        // expected write answers
  int          iq[$];        // expected pulse widths
  int bad_count, compares, cyc, hi_cyc, g;
  bit p1, p2;                // channel polarities in force

  srig_top uut (.clk, .rst, .ce, .first_input_channel, .second_input_channel, .interval_clear,
    .conditioned_signal_jack_one, .conditioned_signal_jack_two, .slope_one, .slope_one_n,
    .slope_two, .slope_two_n, .direct_route_one, .direct_route_two, .interval_out,
    .interval_out_n, .gate_source, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  srig_partner u_far (.clk, .rst, .fire_one, .fire_two, .lat,
    .ch_one(first_input_channel), .ch_two(second_input_channel));

  // free-running clock, 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic flag(input string m);
    bad_count++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic cmp_rd(input logic [33:0] e, input logic [33:0] v);
    compares++;
    if (v !== e) flag($sformatf("read %h expected %h", v, e));
  endtask
  task automatic cmp_wr(input logic [1:0] e, input logic [1:0] v);
    compares++;
    if (v !== e) flag($sformatf("write answer %h expected %h", v, e));
  endtask
  task automatic cmp_wd(input int e, input int v);
    compares++;
    if (v != e) flag($sformatf("width %0d expected %0d", v, e));
  endtask
  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // status word with the generator low
  function automatic logic [31:0] st_exp(input int f, input bit s1, input bit s2);
    logic iv, d1, d2;
    iv = (f == 3) || (f == 6);
    d1 = !iv && (f != 10);
    d2 = d1 && (f != 0) && (f != 9);
    return {24'h0, iv, d2, d1, 1'b0, iv, s2, s1, 1'b0};
  endfunction

  // watcher: answers and pulse widths against the oldest note
  always @(posedge clk) begin
    cyc++;
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
      cmp_rd(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready && wq.size() > 0) cmp_wr(wq.pop_front(), s_axi_bresp);
    if (interval_out === 1'b1) hi_cyc++;
    else begin
      // aborted pulses carry no note
      if (hi_cyc > 0 && iq.size() > 0) cmp_wd(iq.pop_front(), hi_cyc);
      hi_cyc = 0;
    end
    if (cyc > 30000) begin
      flag("timeout");
      give_verdict();
    end
  end

  // write: address and data together, each released when taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    wq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    @(posedge clk);
    rq.push_back(e);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  task automatic fire(input bit two);
    @(posedge clk);
    {fire_two, fire_one} <= two ? 2'b10 : 2'b01;
    @(posedge clk);
    {fire_two, fire_one} <= 2'b00;
  endtask
  // make the next toggle of each channel a qualifying edge
  task automatic arm();
    if (first_input_channel ^ p1) fire(1'b0);
    if (second_input_channel ^ p2) fire(1'b1);
    repeat (30) @(posedge clk);
  endtask

  initial begin
    {rst, ce, interval_clear, fire_one, fire_two, lat} = {1'b1, 1'b1, 7'h00};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {96'h0, 4'hF};
    void'($urandom(32'hEE537BBE));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_STATUS, {RESP_OKAY, st_exp(0, 0, 0)});
    rd(OFF_COUNT, {RESP_OKAY, 32'h0});
    rd(32'h0000_0010, {RESP_SLVERR, 32'h0});
    wr(32'h0000_0014, 32'h0000_0001, RESP_SLVERR);
    $display("test reset done");
    for (int f = 0; f < 12; f++) begin
      wr(OFF_CTRL, f << 4, RESP_OKAY);
      rd(OFF_STATUS, {RESP_OKAY, st_exp(f, 0, 0)});
    end
    $display("test functions done");
    for (int k = 0; k < 4; k++) begin
      {p2, p1} = k[1:0];
      lat <= 4'($urandom_range(0, 7));
      wr(OFF_CTRL, {24'h0, k[0] ? FN_INTERVAL_AVG : FN_INTERVAL_VAR, 2'b00, p2, p1}, RESP_OKAY);
      repeat (2) begin
        arm();
        g = $urandom_range(3, 40);
        iq.push_back(g);
        fire(1'b0);
        repeat (g - 2) @(posedge clk);
        fire(1'b1);
        repeat (30) @(posedge clk);
      end
    end
    rd(OFF_COUNT, {RESP_OKAY, 32'h8});
    $display("test intervals done");
    arm();
    fire(1'b0);
    repeat (24) @(posedge clk);
    interval_clear <= 1'b1;
    @(posedge clk);
    interval_clear <= 1'b0;
    fire(1'b1);
    arm();
    fire(1'b0);
    repeat (24) @(posedge clk);
    wr(OFF_CLEAR, 32'h0000_0001, RESP_OKAY);
    fire(1'b1);
    repeat (30) @(posedge clk);
    rd(OFF_COUNT, {RESP_OKAY, 32'h8});
    rd(OFF_STATUS, {RESP_OKAY, st_exp(6, !first_input_channel, !second_input_channel)});
    $display("test clears done");
    {p2, p1} = 2'b00;
    wr(OFF_CTRL, {24'h0, FN_CHANNEL_ONE_EVENT_SUM, 4'h0}, RESP_OKAY);
    arm();
    fire(1'b0);
    repeat (30) @(posedge clk);
    rd(OFF_STATUS, {RESP_OKAY, st_exp(9, 1, 0)});
    cmp_wd(0, iq.size());
    $display("test totalize done");
    give_verdict();
  end
endmodule
